/* File: sram_window_regs.vh */
/*
  Register layout and constants for the on-chip SRAM window decoder.
  Assumes inclusion by bare name from the design file.
*/
`ifndef SRAM_WINDOW_REGS_VH
`define SRAM_WINDOW_REGS_VH
`define SRAM_WINDOW_BA_MSB 31
`define SRAM_WINDOW_BA_LSB 11
`define SRAM_WINDOW_BUS_BIT 7
`define SRAM_WINDOW_RSVD_BIT 6
`define SRAM_WINDOW_CPU_MASK_BIT 5
`define SRAM_WINDOW_SUP_CODE_BIT 4
`define SRAM_WINDOW_SUP_DATA_BIT 3
`define SRAM_WINDOW_USR_CODE_BIT 2
`define SRAM_WINDOW_USR_DATA_BIT 1
`define SRAM_WINDOW_VALID_BIT 0
`define SRAM_WINDOW_WP_BIT 8
`define SRAM_WINDOW_RESET 32'h00000000
`define SRAM_WINDOW_WMASK 32'hFFFFF9BF
`define SRAM_WINDOW_SEL0 12'hC04
`define SRAM_WINDOW_SEL1 12'hC05
`define SPACE_CPU 3'h0
`define SPACE_SUP_CODE 3'h1
`define SPACE_SUP_DATA 3'h2
`define SPACE_USR_CODE 3'h3
`define SPACE_USR_DATA 3'h4
`endif

/* File: onchip_sram_window_decoder.v */
/*
  Two 2-Kbyte on-chip SRAM modules, their window base registers, and the
  hit logic for the core's instruction and data buses.
  Assumes the core presents one request per bus per cycle, same clock,
  and writes window registers through a control-register port.
  SRAM contents are left as they are by reset; only the windows close.
*/
`include "sram_window_regs.vh"

// How it works
// - Two 2-Kbyte SRAMs, one-cycle pipelined access
// - Base anywhere on 2-Kbyte alignment
// - Each module serves instruction or data bus
// - Register: base, write-protect, space masks, enable
// - Bits 5..1 mask five address spaces
// - Masked space misses, goes external
// - Bit 0 enables module, reset clears it
// - After reset both modules disabled
// - Bit 7 zero data bus, one instruction
module onchip_sram_window_decoder #(
  parameter AW = 9
)(
  input wire clk_i,
  input wire nrst_i,
  input wire ctl_wr_i,
  input wire ctl_rd_i,
  input wire [11:0] ctl_sel_i,
  input wire [31:0] ctl_wdata_i,
  output reg [31:0] ctl_rdata_o,
  input wire ibus_req_i,
  input wire [31:0] ibus_addr_i,
  input wire [2:0] ibus_space_i,
  output reg ibus_hit_o,
  output reg [31:0] ibus_rdata_o,
  input wire dbus_req_i,
  input wire dbus_wr_i,
  input wire [31:0] dbus_addr_i,
  input wire [3:0] dbus_be_i,
  input wire [31:0] dbus_wdata_i,
  input wire [2:0] dbus_space_i,
  output reg dbus_hit_o,
  output reg dbus_wp_err_o,
  output reg [31:0] dbus_rdata_o
);

  reg rst_s1;
  reg rst_s2;
  reg [31:0] sram_window_register0;
  reg [31:0] sram_window_register1;
  reg [31:0] mem0 [0:(1<<AW)-1];
  reg [31:0] mem1 [0:(1<<AW)-1];
  wire ih0;
  wire ih1;
  wire dh0;
  wire dh1;
  wire [AW-1:0] iidx;
  wire [AW-1:0] didx;
  wire sel0;
  wire sel1;
  wire dst0;
  wire dst1;
  wire dprot;

  // Space-mask bit for an address space code
  function space_masked;
    input [31:0] r;
    input [2:0] sp;
    begin
      case (sp)
        `SPACE_CPU: space_masked = r[`SRAM_WINDOW_CPU_MASK_BIT];
        `SPACE_SUP_CODE: space_masked = r[`SRAM_WINDOW_SUP_CODE_BIT];
        `SPACE_SUP_DATA: space_masked = r[`SRAM_WINDOW_SUP_DATA_BIT];
        `SPACE_USR_CODE: space_masked = r[`SRAM_WINDOW_USR_CODE_BIT];
        `SPACE_USR_DATA: space_masked = r[`SRAM_WINDOW_USR_DATA_BIT];
        default: space_masked = 1'b1;
      endcase
    end
  endfunction

  // Hit test of one window against one bus reference
  function window_hit;
    input [31:0] r;
    input ibus;
    input [31:0] a;
    input [2:0] sp;
    begin
      window_hit = r[`SRAM_WINDOW_VALID_BIT]
        & (r[`SRAM_WINDOW_BUS_BIT] == ibus)
        & (a[`SRAM_WINDOW_BA_MSB:`SRAM_WINDOW_BA_LSB]
           == r[`SRAM_WINDOW_BA_MSB:`SRAM_WINDOW_BA_LSB])
        & ~space_masked(r, sp);
    end
  endfunction

  // Byte-lane merge of a store into the word it replaces
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] val;
    input [3:0] be;
    begin
      lane_merge[7:0] = be[0] ? val[7:0] : old[7:0];
      lane_merge[15:8] = be[1] ? val[15:8] : old[15:8];
      lane_merge[23:16] = be[2] ? val[23:16] : old[23:16];
      lane_merge[31:24] = be[3] ? val[31:24] : old[31:24];
    end
  endfunction

  // Reset release synchroniser
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // Window registers; reserved bits and bits 10..9 stay zero
  always @(posedge clk_i or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      sram_window_register0 <= `SRAM_WINDOW_RESET;
      sram_window_register1 <= `SRAM_WINDOW_RESET;
    end
    else if (ctl_wr_i)
    begin
      if (sel0)
        sram_window_register0 <= ctl_wdata_i & `SRAM_WINDOW_WMASK;
      if (sel1)
        sram_window_register1 <= ctl_wdata_i & `SRAM_WINDOW_WMASK;
    end
  end

  // Control-register read
  always @(posedge clk_i or negedge rst_s2)
  begin
    if (!rst_s2)
      ctl_rdata_o <= 32'h00000000;
    else if (ctl_rd_i)
    begin
      if (sel0)
        ctl_rdata_o <= sram_window_register0;
      else if (sel1)
        ctl_rdata_o <= sram_window_register1;
      else
        ctl_rdata_o <= 32'h00000000;
    end
  end

  // Hit decode; module 0 wins if both windows overlap
  assign ih0 = ibus_req_i & window_hit(sram_window_register0, 1'b1, ibus_addr_i,
    ibus_space_i);
  assign ih1 = ibus_req_i & window_hit(sram_window_register1, 1'b1, ibus_addr_i,
    ibus_space_i);
  assign dh0 = dbus_req_i & window_hit(sram_window_register0, 1'b0, dbus_addr_i,
    dbus_space_i);
  assign dh1 = dbus_req_i & window_hit(sram_window_register1, 1'b0, dbus_addr_i,
    dbus_space_i);
  assign iidx = ibus_addr_i[AW+1:2];
  assign didx = dbus_addr_i[AW+1:2];

  // Register select decode
  assign sel0 = (ctl_sel_i == `SRAM_WINDOW_SEL0);
  assign sel1 = (ctl_sel_i == `SRAM_WINDOW_SEL1);

  // Stores: window 0 wins an overlap, so a protected window 0 shields window 1
  assign dst0 = dh0 & dbus_wr_i & ~sram_window_register0[`SRAM_WINDOW_WP_BIT];
  assign dst1 = ~dh0 & dh1 & dbus_wr_i
    & ~sram_window_register1[`SRAM_WINDOW_WP_BIT];
  assign dprot = dbus_wr_i & ((dh0 & sram_window_register0[`SRAM_WINDOW_WP_BIT])
    | (~dh0 & dh1 & sram_window_register1[`SRAM_WINDOW_WP_BIT]));

  // SRAM arrays, written from the data bus unless write-protected
  always @(posedge clk_i)
  begin
    if (dst0)
      mem0[didx] <= lane_merge(mem0[didx], dbus_wdata_i, dbus_be_i);
    else if (dst1)
      mem1[didx] <= lane_merge(mem1[didx], dbus_wdata_i, dbus_be_i);
  end

  // One-cycle answer on the instruction bus
  always @(posedge clk_i or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      ibus_hit_o <= 1'b0;
      ibus_rdata_o <= 32'h00000000;
    end
    else
    begin
      ibus_hit_o <= ih0 | ih1;
      if (ih0)
        ibus_rdata_o <= mem0[iidx];
      else if (ih1)
        ibus_rdata_o <= mem1[iidx];
    end
  end

  // One-cycle answer on the data bus
  always @(posedge clk_i or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      dbus_hit_o <= 1'b0;
      dbus_wp_err_o <= 1'b0;
      dbus_rdata_o <= 32'h00000000;
    end
    else
    begin
      dbus_hit_o <= dh0 | dh1;
      dbus_wp_err_o <= dprot;
      if (dh0 & ~dbus_wr_i)
        dbus_rdata_o <= mem0[didx];
      else if (dh1 & ~dbus_wr_i)
        dbus_rdata_o <= mem1[didx];
    end
  end

endmodule // onchip_sram_window_decoder

/* File: sram_window_asserts.sv */
/* Checker for the SRAM window decoder.
   Assumes it is bound to the top module's ports. */
module sram_window_checker(
  input wire clk_i, nrst_i, ctl_wr_i, ctl_rd_i, ibus_req_i, dbus_req_i, dbus_wr_i,
  input wire ibus_hit_o, dbus_hit_o, dbus_wp_err_o,
  input wire [11:0] ctl_sel_i,
  input wire [31:0] ctl_rdata_o,
  input wire [2:0] ibus_space_i, dbus_space_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic wrote;
  // Set once any control-register write is seen
  always @(posedge clk_i or negedge nrst_i)
    if (!nrst_i) wrote <= 1'b0;
    else if (ctl_wr_i) wrote <= 1'b1;
  ihit_cause_a: assert property (ibus_hit_o |-> $past(ibus_req_i))
    else $error("fetch hit without request");
  dhit_cause_a: assert property (dbus_hit_o |-> $past(dbus_req_i) && $past(dbus_space_i) < 5)
    else $error("data hit without valid request");
  ispace_block_a: assert property (ibus_req_i && ibus_space_i > 4 |=> !ibus_hit_o)
    else $error("fetch hit on unknown space");
  reset_off_a: assert property (!wrote |=> !ibus_hit_o && !dbus_hit_o)
    else $error("hit before any window set");
  wp_write_a: assert property (dbus_wp_err_o |-> dbus_hit_o && $past(dbus_wr_i))
    else $error("protect error without write hit");
  rsvd_zero_a: assert property (ctl_rd_i |=> ctl_rdata_o[10:9] == 0 && !ctl_rdata_o[6])
    else $error("reserved bits read nonzero");
  unk_sel_a: assert property (ctl_rd_i && ctl_sel_i != 12'hC04 && ctl_sel_i != 12'hC05
    |=> ctl_rdata_o == 0)
    else $error("unknown select read nonzero");
  hit_pulse_a: assert property (ibus_hit_o && !ibus_req_i |=> !ibus_hit_o)
    else $error("fetch hit held too long");
  cover property (ibus_hit_o);
  cover property (dbus_wp_err_o);
  cover property (dbus_req_i && dbus_space_i == 0 ##1 !dbus_hit_o);
endmodule // sram_window_checker
bind onchip_sram_window_decoder sram_window_checker chk(.*);

/* File: core_fetch_model.sv */
/* Core instruction bus model: one fetch per go pulse.
   Assumes go_i is raised by the bench one falling edge ahead. */
module core_fetch_model(
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [31:0] a_i,
  input wire logic [2:0] sp_i,
  output logic req_o = 1'b0,
  output logic [31:0] addr_o = 32'h0,
  output logic [2:0] space_o = 3'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Drive off the falling edge; a released address flips to its inverse on every falling edge
  always @(negedge clk_i)
  begin
    req_o <= go_i;
    addr_o <= go_i ? a_i : ~addr_o;
    space_o <= sp_i;
  end
endmodule // core_fetch_model

/* File: test_onchip_sram_window_decoder.sv */
/* Testbench for the SRAM window decoder.
   Assumes the checker and the fetch model are compiled first. */
module test_onchip_sram_window_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, nrst_i = 0, ctl_wr_i = 0, ctl_rd_i = 0, dbus_req_i = 0, dbus_wr_i = 0, go = 0;
  logic [11:0] ctl_sel_i = 0;
  logic [31:0] ctl_wdata_i = 0, dbus_addr_i = 0, dbus_wdata_i = 0, fa = 0, ibus_addr_i;
  logic [2:0] dbus_space_i = 0, fs = 0, ibus_space_i;
  logic [3:0] dbus_be_i = 4'hF;
  logic ibus_req_i;
  wire [31:0] ctl_rdata_o, ibus_rdata_o, dbus_rdata_o;
  wire ibus_hit_o, dbus_hit_o, dbus_wp_err_o;
  int n_fail = 0, comparisons = 0, cyc = 0, s;
  always #12.5 clk_i = ~clk_i;
  onchip_sram_window_decoder uut(
    .clk_i(clk_i), .nrst_i(nrst_i), .ctl_wr_i(ctl_wr_i), .ctl_rd_i(ctl_rd_i),
    .ctl_sel_i(ctl_sel_i), .ctl_wdata_i(ctl_wdata_i), .ctl_rdata_o(ctl_rdata_o),
    .ibus_req_i(ibus_req_i), .ibus_addr_i(ibus_addr_i), .ibus_space_i(ibus_space_i),
    .ibus_hit_o(ibus_hit_o), .ibus_rdata_o(ibus_rdata_o), .dbus_req_i(dbus_req_i),
    .dbus_wr_i(dbus_wr_i), .dbus_addr_i(dbus_addr_i), .dbus_be_i(dbus_be_i),
    .dbus_wdata_i(dbus_wdata_i), .dbus_space_i(dbus_space_i), .dbus_hit_o(dbus_hit_o),
    .dbus_wp_err_o(dbus_wp_err_o), .dbus_rdata_o(dbus_rdata_o));
  core_fetch_model core(.clk_i, .go_i(go), .a_i(fa), .sp_i(fs), .req_o(ibus_req_i),
    .addr_o(ibus_addr_i), .space_o(ibus_space_i));
  task chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin n_fail++; $display("Error %0t got %h want %h", $time, g, e); end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    @(negedge clk_i) {ctl_wr_i, ctl_sel_i, ctl_wdata_i} <= {1'b1, a, d};
    @(negedge clk_i) ctl_wr_i <= 0;
  endtask
  task rd(input [11:0] a, input [31:0] e);
    @(negedge clk_i) {ctl_rd_i, ctl_sel_i} <= {1'b1, a};
    @(negedge clk_i) ctl_rd_i <= 0;
    chk(ctl_rdata_o, e);
  endtask
  task da(input w, input [31:0] a, input [2:0] sp, input [31:0] d, input h, p, input [31:0] e);
    @(negedge clk_i) {dbus_req_i, dbus_wr_i, dbus_addr_i, dbus_space_i, dbus_wdata_i}
      <= {1'b1, w, a, sp, d};
    @(negedge clk_i) {dbus_req_i, dbus_addr_i} <= {1'b0, ~a};
    chk(dbus_hit_o, h);
    chk(dbus_wp_err_o, p);
    if (h && !w) chk(dbus_rdata_o, e);
  endtask
  task fe(input [31:0] a, input [2:0] sp, input h, input [31:0] e);
    @(negedge clk_i) {go, fa, fs} <= {1'b1, a, sp};
    @(negedge clk_i) go <= 0;
    @(negedge clk_i) chk(ibus_hit_o, h);
    if (h) chk(ibus_rdata_o, e);
  endtask
  task tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clk_i) if (++cyc == 3000) begin n_fail++; tally_and_finish; end
  // Main sequence
  initial
  begin
    repeat (16) @(negedge clk_i);
    nrst_i <= 1;
    repeat (3) @(negedge clk_i);
    rd(12'hC04, 0);
    rd(12'hC05, 0);
    fe(32'h800, 1, 0, 0);
    wr(12'hC05, 32'hFFFFFFBE);
    rd(12'hC05, 32'hFFFFF9BE);
    wr(12'hC04, 32'h20000801);
    rd(12'hC04, 32'h20000801);
    rd(12'h123, 0);
    da(1, 32'h20000804, 1, 32'hA5A50F0F, 1, 0, 0);
    da(0, 32'h20000804, 1, 0, 1, 0, 32'hA5A50F0F);
    da(0, 32'h20001004, 1, 0, 0, 0, 0);
    fe(32'h20000804, 1, 0, 0);
    wr(12'hC05, 32'h40000821);
    da(1, 32'h40000800, 2, 32'h13572468, 1, 0, 0);
    wr(12'hC05, 32'h40000881);
    fe(32'h40000800, 3, 1, 32'h13572468);
    fe(32'h40000800, 5, 0, 0);
    for (s = 0; s < 5; s++)
    begin
      wr(12'hC04, 32'h20000801 | (32'h1 << (5 - s)));
      da(0, 32'h20000804, s[2:0], 0, 0, 0, 0);
      da(0, 32'h20000804, 3'((s + 1) % 5), 0, 1, 0, 32'hA5A50F0F);
    end
    wr(12'hC04, 32'h20000901);
    da(1, 32'h20000804, 1, 32'h1234, 1, 1, 0);
    da(0, 32'h20000804, 1, 0, 1, 0, 32'hA5A50F0F);
    wr(12'hC05, 32'h00000021);
    da(1, 32'h00000004, 2, 32'h5A5AC3C3, 1, 0, 0);
    dbus_be_i <= 4'h1;
    da(1, 32'h00000004, 2, 32'h000000EE, 1, 0, 0);
    dbus_be_i <= 4'hF;
    da(0, 32'h00000004, 4, 0, 1, 0, 32'h5A5AC3EE);
    da(0, 32'h00000004, 0, 0, 0, 0, 0);
    // Reset again in mid-run: window 1 must close
    @(negedge clk_i) nrst_i <= 0;
    repeat (2) @(negedge clk_i);
    nrst_i <= 1;
    repeat (3) @(negedge clk_i);
    rd(12'hC05, 0);
    da(0, 32'h00000004, 4, 0, 0, 0, 0);
    tally_and_finish;
  end
endmodule // test_onchip_sram_window_decoder
